// File: sra_pkg.sv
// shared constants and types for the spi register and ram access front end
package sra_pkg;

  // ****************************************
  // instruction codes
  // ****************************************
  localparam logic [3:0] CMD_RESET = 4'h0;
  localparam logic [3:0] CMD_WRITE = 4'h2;
  localparam logic [3:0] CMD_READ = 4'h3;
  localparam logic [3:0] CMD_WRITE_CRC = 4'ha;
  localparam logic [3:0] CMD_READ_CRC = 4'hb;
  localparam logic [3:0] CMD_WRITE_SAFE = 4'hc;

  // ****************************************
  // address map and wrap points
  // ****************************************
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [11:0] REG_LO_START = 12'h000;
  localparam logic [11:0] REG_LO_END = 12'h3ff;
  localparam logic [11:0] REG_HI_START = 12'he00;
  localparam logic [11:0] REG_HI_END = 12'hfff;
  localparam logic [11:0] RAM_START = 12'h400;
  localparam logic [11:0] RAM_END = 12'hbff;

  // ****************************************
  // check value and frame counts
  // ****************************************
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [3:0] HDR_LAST = 4'hf;
  localparam logic [3:0] CRC_LAST = 4'hf;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [1:0] LANE_LAST = 2'h3;
  localparam int FIFO_DEPTH = 32;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_COUNT,
    ST_DATA,
    ST_CRC,
    ST_DONE
  } sra_state_t;

  // one committed write: byte for registers, word for ram
  typedef struct packed {
    logic ram;
    logic [11:0] addr;
    logic [31:0] data;
  } sra_wr_t;

  localparam int WR_W = $bits(sra_wr_t);

endpackage

// File: sra_fifo.sv
// write commit fifo with registered output stage
`timescale 1ns/1ps
module sra_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clocking
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // full and empty come straight from the count
  assign in_ready = count_reg != (AW+1)'(DEPTH);
  assign push = in_valid && in_ready;
  assign pop = (count_reg != '0) && (!out_valid || out_ready);

  // storage, one writer per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge core_clk) begin
      if (clk_en && push && wr_ptr_reg == AW'(i)) begin
        mem_reg[i] <= in_data;
      end
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // output stage keeps the drain side on flip-flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (clk_en) begin
      if (pop) begin
        out_valid <= 1'b1;
        out_data <= mem_reg[rd_ptr_reg];
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule

// File: sra_spi_front.sv
// spi instruction front end for register and message ram access
`timescale 1ns/1ps
module sra_spi_front #(
  parameter int FIFO_DEPTH = sra_pkg::FIFO_DEPTH
) (
  // system
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // spi pins
  input wire logic sck,
  input wire logic select_low,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // register and ram read port
  output logic rd_req,
  output logic rd_ram,
  output logic [11:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [31:0] rd_data,
  // write commit stream
  output logic wr_valid,
  output sra_pkg::sra_wr_t wr_entry,
  input wire logic wr_ready,
  // status
  output logic device_reset,
  output logic check_error_flag,
  output logic check_frame_error_flag,
  input wire logic flag_clear
);

  // ****************************************
  // declarations
  // ****************************************
  logic [2:0] sck_s_reg;
  logic [2:0] sel_s_reg;
  logic [1:0] sdi_s_reg;
  logic sck_rise, sck_fall, sel_rise, sel_fall;
  sra_pkg::sra_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [3:0] cmd_reg;
  logic [14:0] shift_reg;
  logic [11:0] addr_reg;
  logic [9:0] total_reg;
  logic [9:0] byte_cnt_reg;
  logic [15:0] crc_reg;
  logic [15:0] out_reg;
  logic [31:0] word_reg;
  logic [31:0] rd_word_reg;
  logic ram_reg, byte_done_reg, safe_ok_reg, reset_pend_reg, push_pend_reg;
  sra_pkg::sra_wr_t commit_reg;
  sra_pkg::sra_wr_t push_entry_reg;
  sra_pkg::sra_wr_t pend_entry;
  logic [15:0] hdr, crc_next, load_val;
  logic [7:0] rx_byte;
  logic [1:0] lane;
  logic rbit, is_read, is_write, is_crc, is_safe, rd_phase, in_body;
  logic byte_end, crc_end, hdr_ok, ram_hit, word_end, err_set, frame_set, push_ready;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [11:0] addr_step(input logic [11:0] a, input logic ram);
    logic [11:0] n;
    n = a + 12'h001;
    if (ram && a == sra_pkg::RAM_END) begin
      n = sra_pkg::RAM_START;
    end else if (!ram && a == sra_pkg::REG_LO_END) begin
      n = sra_pkg::REG_LO_START;
    end else if (!ram && a == sra_pkg::REG_HI_END) begin
      n = sra_pkg::REG_HI_START;
    end
    return n;
  endfunction

  // msb first, no final inversion
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? sra_pkg::CRC_POLY : 16'h0000);
  endfunction

  // ****************************************
  // pin synchronisers and edge finding
  // ****************************************
  // sck is sampled, not used as a clock, hence the half-rate limit
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sck_s_reg <= 3'h0;
      sel_s_reg <= 3'h7;
      sdi_s_reg <= 2'h0;
    end else if (clk_en) begin
      sck_s_reg <= {sck_s_reg[1:0], sck};
      sel_s_reg <= {sel_s_reg[1:0], select_low};
      sdi_s_reg <= {sdi_s_reg[0], sdi};
    end
  end

  assign sck_rise = sck_s_reg[1] && !sck_s_reg[2];
  assign sck_fall = !sck_s_reg[1] && sck_s_reg[2];
  assign sel_fall = !sel_s_reg[1] && sel_s_reg[2];
  assign sel_rise = sel_s_reg[1] && !sel_s_reg[2];

  // ****************************************
  // decode
  // ****************************************
  assign is_read = cmd_reg == sra_pkg::CMD_READ || cmd_reg == sra_pkg::CMD_READ_CRC;
  assign is_safe = cmd_reg == sra_pkg::CMD_WRITE_SAFE;
  assign is_write = cmd_reg == sra_pkg::CMD_WRITE || cmd_reg == sra_pkg::CMD_WRITE_CRC || is_safe;
  assign is_crc = cmd_reg == sra_pkg::CMD_READ_CRC || cmd_reg == sra_pkg::CMD_WRITE_CRC || is_safe;
  assign in_body = state_reg == sra_pkg::ST_COUNT || state_reg == sra_pkg::ST_DATA
    || state_reg == sra_pkg::ST_CRC;
  assign rd_phase = is_read && (state_reg == sra_pkg::ST_DATA || state_reg == sra_pkg::ST_CRC);
  // on reads the check value runs over the bit just driven out
  assign rbit = rd_phase ? sdo : sdi_s_reg[1];
  assign hdr = {shift_reg, rbit};
  assign rx_byte = hdr[7:0];
  assign lane = addr_reg[1:0];
  assign word_end = !ram_reg || lane == sra_pkg::LANE_LAST;
  assign byte_end = sck_rise && bit_cnt_reg[2:0] == sra_pkg::BYTE_LAST;
  assign crc_end = sck_rise && state_reg == sra_pkg::ST_CRC && bit_cnt_reg == sra_pkg::CRC_LAST;
  assign crc_next = crc_step(crc_reg, rbit);
  assign ram_hit = hdr[11:0] >= sra_pkg::RAM_START && hdr[11:0] <= sra_pkg::RAM_END;

  // only the six defined instructions are accepted, the reset instruction only with address 000
  always_comb begin
    case (hdr[15:12])
      sra_pkg::CMD_READ, sra_pkg::CMD_WRITE, sra_pkg::CMD_READ_CRC,
      sra_pkg::CMD_WRITE_CRC, sra_pkg::CMD_WRITE_SAFE: hdr_ok = 1'b1;
      sra_pkg::CMD_RESET: hdr_ok = hdr[11:0] == sra_pkg::ADDR_RESET;
      default: hdr_ok = 1'b0;
    endcase
  end

  // entry for the byte or word completing now
  always_comb begin
    pend_entry.ram = ram_reg;
    pend_entry.addr = addr_reg;
    pend_entry.data = {24'h00_0000, rx_byte};
    if (ram_reg) begin
      pend_entry.addr = {addr_reg[11:2], 2'h0};
      pend_entry.data = {rx_byte, word_reg[23:0]};
    end
  end

  // ****************************************
  // instruction sequencer
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= sra_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      cmd_reg <= 4'h0;
      shift_reg <= 15'h0000;
      addr_reg <= 12'h000;
      ram_reg <= 1'b0;
      total_reg <= 10'h000;
      byte_cnt_reg <= 10'h000;
      word_reg <= 32'h0000_0000;
      commit_reg <= '0;
      byte_done_reg <= 1'b0;
      safe_ok_reg <= 1'b0;
      reset_pend_reg <= 1'b0;
      rd_req <= 1'b0;
      rd_ram <= 1'b0;
      rd_addr <= 12'h000;
    end else if (clk_en) begin
      rd_req <= 1'b0;
      if (sel_rise) begin
        // frame end also drops any partial ram word
        state_reg <= sra_pkg::ST_IDLE;
        byte_done_reg <= 1'b0;
        safe_ok_reg <= 1'b0;
        reset_pend_reg <= 1'b0;
      end else if (sel_fall) begin
        state_reg <= sra_pkg::ST_CMD;
        bit_cnt_reg <= 4'h0;
      end else if (sck_rise) begin
        shift_reg <= hdr[14:0];
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        case (state_reg)
          sra_pkg::ST_CMD: begin
            if (bit_cnt_reg == sra_pkg::HDR_LAST) begin
              cmd_reg <= hdr[15:12];
              addr_reg <= hdr[11:0];
              ram_reg <= ram_hit;
              bit_cnt_reg <= 4'h0;
              byte_cnt_reg <= 10'h000;
              if (!hdr_ok) begin
                state_reg <= sra_pkg::ST_DONE;
              end else if (hdr[15:12] == sra_pkg::CMD_RESET) begin
                reset_pend_reg <= 1'b1;
                state_reg <= sra_pkg::ST_DONE;
              end else if (hdr[15:12] == sra_pkg::CMD_READ_CRC || hdr[15:12] == sra_pkg::CMD_WRITE_CRC) begin
                state_reg <= sra_pkg::ST_COUNT;
              end else begin
                state_reg <= sra_pkg::ST_DATA;
                if (hdr[15:12] == sra_pkg::CMD_READ) begin
                  rd_req <= 1'b1;
                  rd_ram <= ram_hit;
                  rd_addr <= ram_hit ? {hdr[11:2], 2'h0} : hdr[11:0];
                end
              end
            end
          end
          sra_pkg::ST_COUNT: begin
            if (byte_end) begin
              // ram counts words, registers count bytes
              total_reg <= ram_reg ? {rx_byte, 2'h0} : {2'h0, rx_byte};
              bit_cnt_reg <= 4'h0;
              state_reg <= (rx_byte == 8'h00) ? sra_pkg::ST_CRC : sra_pkg::ST_DATA;
              if (is_read) begin
                rd_req <= 1'b1;
                rd_ram <= ram_reg;
                rd_addr <= ram_reg ? {addr_reg[11:2], 2'h0} : addr_reg;
              end
            end
          end
          sra_pkg::ST_DATA: begin
            if (byte_end) begin
              bit_cnt_reg <= 4'h0;
              byte_cnt_reg <= byte_cnt_reg + 10'h001;
              addr_reg <= addr_step(addr_reg, ram_reg);
              if (is_write) begin
                word_reg[lane*8 +: 8] <= rx_byte;
                if (word_end) begin
                  commit_reg <= pend_entry;
                  byte_done_reg <= !is_safe;
                end
              end
              if (is_read && word_end) begin
                rd_req <= 1'b1;
                rd_ram <= ram_reg;
                rd_addr <= ram_reg ? {addr_step(addr_reg, ram_reg)} : addr_step(addr_reg, ram_reg);
              end
              if ((is_crc && !is_safe && byte_cnt_reg + 10'h001 == total_reg) || (is_safe && word_end)) begin
                state_reg <= sra_pkg::ST_CRC;
              end
            end
          end
          sra_pkg::ST_CRC: begin
            if (bit_cnt_reg == sra_pkg::CRC_LAST) begin
              state_reg <= sra_pkg::ST_DONE;
              // appended check bytes leave a zero residue when intact
              safe_ok_reg <= is_safe && crc_next == sra_pkg::CRC_RESIDUE;
            end
          end
          default: ;
        endcase
      end else if (sck_fall) begin
        byte_done_reg <= 1'b0;
        safe_ok_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // check value
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      crc_reg <= sra_pkg::CRC_INIT;
    end else if (clk_en) begin
      if (sel_fall) begin
        crc_reg <= sra_pkg::CRC_INIT;
      end else if (sck_rise && (state_reg == sra_pkg::ST_CMD || in_body)) begin
        crc_reg <= crc_next;
      end
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  assign load_val = (state_reg == sra_pkg::ST_CRC) ? crc_reg
    : {ram_reg ? rd_word_reg[lane*8 +: 8] : rd_word_reg[7:0], 8'h00};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      out_reg <= 16'h0000;
    end else if (clk_en) begin
      sdo_oe <= !sel_s_reg[1] && rd_phase;
      if (sck_fall && rd_phase) begin
        if (bit_cnt_reg == 4'h0) begin
          sdo <= load_val[15];
          out_reg <= {load_val[14:0], 1'b0};
        end else begin
          sdo <= out_reg[15];
          out_reg <= {out_reg[14:0], 1'b0};
        end
      end
    end
  end

  // read data is held until the next fetch answers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_word_reg <= 32'h0000_0000;
    end else if (clk_en && rd_valid) begin
      rd_word_reg <= rd_data;
    end
  end

  // ****************************************
  // commit into the write fifo
  // ****************************************
  // a full fifo holds the commit; a second commit meanwhile overwrites it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      push_pend_reg <= 1'b0;
      push_entry_reg <= '0;
    end else if (clk_en) begin
      if (sck_fall && (byte_done_reg || safe_ok_reg)) begin
        push_pend_reg <= 1'b1;
        push_entry_reg <= commit_reg;
      end else if (push_ready) begin
        push_pend_reg <= 1'b0;
      end
    end
  end

  sra_fifo #(
    .WIDTH(sra_pkg::WR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .in_valid(push_pend_reg),
    .in_ready(push_ready),
    .in_data(push_entry_reg),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_entry)
  );

  // ****************************************
  // device reset and status flags
  // ****************************************
  // ram is not on this path, so its contents survive
  always_ff @(posedge core_clk) begin
    if (reset) begin
      device_reset <= 1'b0;
    end else if (clk_en) begin
      device_reset <= sel_rise && reset_pend_reg;
    end
  end

  assign err_set = crc_end && is_write && crc_next != sra_pkg::CRC_RESIDUE;
  assign frame_set = sel_rise && is_crc && in_body;

  // set wins over flag_clear in the same cycle; device_reset clears both flags over a set
  always_ff @(posedge core_clk) begin
    if (reset) begin
      check_error_flag <= 1'b0;
      check_frame_error_flag <= 1'b0;
    end else if (clk_en) begin
      if (device_reset) begin
        check_error_flag <= 1'b0;
        check_frame_error_flag <= 1'b0;
      end else begin
        if (err_set) begin
          check_error_flag <= 1'b1;
        end else if (flag_clear) begin
          check_error_flag <= 1'b0;
        end
        if (frame_set) begin
          check_frame_error_flag <= 1'b1;
        end else if (flag_clear) begin
          check_frame_error_flag <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_crc_start_ones: assert property (clk_en && sel_fall |=> crc_reg == sra_pkg::CRC_INIT)
    else $error("check value not reset at select");
  a_reset_at_end: assert property (clk_en && sel_rise && reset_pend_reg |=> device_reset)
    else $error("reset instruction missed at select rise");
  a_reset_only_end: assert property ($rose(device_reset) |-> $past(sel_rise && reset_pend_reg))
    else $error("device reset without reset instruction");
  a_frame_err_set: assert property (clk_en && sel_rise && is_crc && in_body |=> check_frame_error_flag)
    else $error("frame error flag not set");
  a_bad_cmd_ignored: assert property (clk_en && sck_rise && state_reg == sra_pkg::ST_CMD
    && bit_cnt_reg == sra_pkg::HDR_LAST && !hdr_ok |=> state_reg == sra_pkg::ST_DONE
    && !reset_pend_reg ##1 !sdo_oe)
    else $error("undefined command not ignored");
  a_reg_addr_wrap: assert property (clk_en && byte_end && state_reg == sra_pkg::ST_DATA
    && !ram_reg && addr_reg == sra_pkg::REG_HI_END |=> addr_reg == sra_pkg::REG_HI_START)
    else $error("register address wrap wrong");
  a_ram_addr_wrap: assert property (clk_en && byte_end && state_reg == sra_pkg::ST_DATA
    && ram_reg && addr_reg == sra_pkg::RAM_END |=> addr_reg == sra_pkg::RAM_START)
    else $error("ram address wrap wrong");
  a_commit_on_fall: assert property (clk_en && sck_fall && byte_done_reg |=> push_pend_reg
    && push_entry_reg == $past(commit_reg))
    else $error("write not committed on falling edge");
  a_safe_bad_flag: assert property (clk_en && crc_end && is_safe && crc_next != sra_pkg::CRC_RESIDUE
    |=> check_error_flag && !safe_ok_reg)
    else $error("bad verified write not flagged");
  a_sdo_on_fall: assert property (clk_en && !$stable(sdo) |-> $past(sck_fall))
    else $error("serial output moved off a falling edge");
  a_hdr_sampled: assert property (clk_en && sck_rise && state_reg == sra_pkg::ST_CMD
    |=> shift_reg[0] == $past(sdi_s_reg[1]))
    else $error("header bit not sampled");

  c_reset_instr: cover property (device_reset);
  c_safe_commit: cover property (clk_en && sck_fall && safe_ok_reg);
  c_read_crc_out: cover property (rd_phase && state_reg == sra_pkg::ST_CRC && sck_fall);
  c_frame_error: cover property (frame_set);

endmodule

// File: sra_host_model.sv
// spi host model driving the front end pins in mode 0,0
`timescale 1ns/1ps
module sra_host_model (
  // spi pins
  output logic sck,
  output logic select_low,
  output logic sdi,
  input wire logic sdo
);
  logic [15:0] crc;
  // idle: deselected, clock low, only moves inside frames
  initial begin
    sck = 1'b0;
    select_low = 1'b1;
    sdi = 1'b0;
    crc = 16'hffff;
  end
  // one 8-bit unit msb first; sdi moves while sck is low, read back at the rise
  task automatic xfer(input logic [7:0] tx, input logic rd, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      #200 sck = 1'b1;
      rx[i] = sdo;
      crc = {crc[14:0], 1'b0} ^ (((rd ? sdo : tx[i]) ^ crc[15]) ? 16'h8005 : 16'h0000);
      #200 sck = 1'b0;
    end
  endtask
  // frame edge; odd offset keeps the link out of phase with core_clk
  task automatic sel(input logic lo);
    #407 select_low = lo;
    crc = 16'hffff;
    sdi = ~sdi;
    #400;
  endtask
endmodule

// File: spi_register_ram_access_test.sv
// self-checking bench for the spi register and ram front end
`timescale 1ns/1ps
module spi_register_ram_access_test;
  logic core_clk, sck, select_low, sdi, sdo, sdo_oe, rd_req, rd_ram, wr_valid;
  logic device_reset, check_error_flag, check_frame_error_flag;
  logic reset, flag_clear, clk_en, gate, en, rd_valid, wr_ready;
  logic [11:0] rd_addr, a;
  logic [31:0] rd_data, seed = 32'ha43f, r, b, w;
  logic [7:0] rx;
  logic [15:0] c;
  sra_pkg::sra_wr_t wr_entry;
  logic [44:0] exp_q[$];
  int err_total = 0, tests_run = 0, resets_seen = 0;
  sra_spi_front #(.FIFO_DEPTH(32)) i_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .sck(sck),
    .select_low(select_low), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .rd_req(rd_req), .rd_ram(rd_ram),
    .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .wr_valid(wr_valid), .wr_entry(wr_entry),
    .wr_ready(wr_ready), .device_reset(device_reset), .check_error_flag(check_error_flag),
    .check_frame_error_flag(check_frame_error_flag), .flag_clear(flag_clear));
  sra_host_model i_host (.sck(sck), .select_low(select_low), .sdi(sdi), .sdo(sdo));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] rb(input logic [11:0] ad);
    return ad[7:0] ^ {ad[11:8], 4'h6};
  endfunction
  task automatic check(input logic [44:0] seen, input logic [44:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hdr(input logic [3:0] cm, input logic [11:0] ad);
    i_host.sel(1'b0);
    i_host.xfer({cm, ad[11:8]}, 1'b0, rx);
    i_host.xfer(ad[7:0], 1'b0, rx);
  endtask
  task automatic crc_out(input logic [15:0] flip);
    c = i_host.crc ^ flip;
    i_host.xfer(c[15:8], 1'b0, rx);
    i_host.xfer(c[7:0], 1'b0, rx);
  endtask
  task automatic clr();
    @(negedge core_clk) flag_clear = 1'b1;
    @(negedge core_clk) flag_clear = 1'b0;
  endtask
  // read port answers next cycle, garbage otherwise; sink stalls at random and compares commits
  // enable drops single cycles while gated, never two in a row, so no sck level is lost
  always @(negedge core_clk) begin
    r = rnd();
    en = reset || !gate || r[4:2] != 3'h0 || !clk_en;
    clk_en <= en;
    rd_valid <= rd_req;
    rd_data <= !rd_req ? r : rd_ram ? {rb(rd_addr + 3), rb(rd_addr + 2), rb(rd_addr + 1), rb(rd_addr)} : rb(rd_addr);
    if (!reset && wr_valid && r[1] && en) begin
      if (exp_q.size() == 0)
        check(wr_entry, ~wr_entry);
      else
        check(wr_entry, exp_q.pop_front());
    end
    wr_ready <= r[1];
    if (device_reset) resets_seen++;
  end
  // watchdog, far beyond the expected run of about 260 us
  initial begin
    #2_000_000 err_total++;
    final_report();
  end
  initial begin
    reset = 1'b1;
    flag_clear = 1'b0;
    gate = 1'b0;
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    gate = 1'b1;
    // register writes across both wrap points
    for (int k = 0; k < 2; k++) begin
      hdr(4'h2, k ? 12'hfff : 12'h3ff);
      for (int j = 0; j < 2; j++) begin
        b = rnd();
        exp_q.push_back({1'b0, j ? (k ? 12'he00 : 12'h000) : (k ? 12'hfff : 12'h3ff), 24'h00_0000, b[7:0]});
        i_host.xfer(b[7:0], 1'b0, rx);
      end
      i_host.sel(1'b1);
    end
    // ram write over the wrap, then a cut partial word that must vanish
    hdr(4'h2, 12'hbfc);
    for (int j = 0; j < 10; j++) begin
      if (j % 4 == 0) w = rnd();
      if (j == 3) exp_q.push_back({1'b1, 12'hbfc, w});
      if (j == 7) exp_q.push_back({1'b1, 12'h400, w});
      i_host.xfer(w[8 * (j % 4) +: 8], 1'b0, rx);
    end
    i_host.sel(1'b1);
    gate = 1'b0;
    // register and ram reads over the wrap points
    for (int k = 0; k < 2; k++) begin
      a = k ? 12'hbfc : 12'h3fc;
      hdr(4'h3, a);
      for (int j = 0; j < 8; j++) begin
        b = rnd();
        i_host.xfer(b[7:0], 1'b1, rx);
        check(rx, rb(a));
        a = (a == 12'h3ff) ? 12'h000 : (a == 12'hbff) ? 12'h400 : a + 12'h001;
      end
      check(sdo_oe, 1'b1);
      i_host.sel(1'b1);
    end
    // checked read: count, one byte, then the two check bytes
    hdr(4'hb, 12'h010);
    i_host.xfer(8'h01, 1'b0, rx);
    i_host.xfer(8'h00, 1'b1, rx);
    check(rx, rb(12'h010));
    c = i_host.crc;
    i_host.xfer(8'h00, 1'b0, rx);
    check(rx, c[15:8]);
    i_host.xfer(8'h00, 1'b0, rx);
    check(rx, c[7:0]);
    i_host.sel(1'b1);
    // checked write, verified write with a bad then a good check value
    for (int k = 0; k < 3; k++) begin
      hdr(k ? 4'hc : 4'ha, 12'h020);
      if (k == 0) i_host.xfer(8'h01, 1'b0, rx);
      b = rnd();
      if (k != 1) exp_q.push_back({1'b0, 12'h020, 24'h00_0000, b[7:0]});
      i_host.xfer(b[7:0], 1'b0, rx);
      crc_out(k == 1 ? 16'h0100 : 16'h0000);
      i_host.sel(1'b1);
      check(check_error_flag, k == 1);
      clr();
    end
    // verified write cut inside the check field
    hdr(4'hc, 12'h030);
    i_host.xfer(8'h3c, 1'b0, rx);
    i_host.xfer(8'h00, 1'b0, rx);
    i_host.sel(1'b1);
    check(check_frame_error_flag, 1'b1);
    // undefined command stays silent
    hdr(4'h5, 12'h040);
    i_host.xfer(8'h00, 1'b1, rx);
    check(sdo_oe, 1'b0);
    i_host.sel(1'b1);
    // reset instruction acts only at the select rise and clears the flags
    hdr(4'h0, 12'h000);
    check(resets_seen, 0);
    i_host.sel(1'b1);
    check(resets_seen, 1);
    check(check_frame_error_flag, 1'b0);
    repeat (200) @(negedge core_clk);
    check(exp_q.size(), 0);
    final_report();
  end
endmodule
